// *** core/usi_pkg.sv ***
// usi_pkg: register map, field positions and carrier structs for the serial shift core
// assumes a 32-bit AXI4-Lite master and one clk_sys domain on the register side
package usi_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_DATA = 8'h00;
    localparam logic [7:0] ADDR_BUFFER = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_CONTROL = 8'h0C;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // status bits
    localparam int ST_START = 7;
    localparam int ST_OVF = 6;
    localparam int ST_STOP = 5;
    localparam int ST_COLL = 4;
    // control bits
    localparam int CT_SIE = 7;
    localparam int CT_OIE = 6;
    localparam int CT_WM_HI = 5;
    localparam int CT_WM_LO = 4;
    localparam int CT_CS_HI = 3;
    localparam int CT_CS_LO = 2;
    localparam int CT_CLK = 1;
    localparam int CT_TC = 0;
    localparam logic [3:0] CNT_MAX = 4'hF;
    localparam logic [3:0] CNT_ONE = 4'h1;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [1:0] WM_OFF = 2'h0;
    localparam logic [1:0] WM_THREE = 2'h1;
    localparam logic [1:0] WM_TWO_HOLD = 2'h3;
    localparam logic [1:0] CS_SOFT = 2'h0;
    localparam logic [1:0] CS_TIMER = 2'h1;

    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } axi_in_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axi_out_t;

    typedef struct packed {
        logic serialClockPin;
        logic serialInPin;
        logic portData;
        logic portClock;
        logic dirData;
        logic dirClock;
    } pin_in_t;

    typedef struct packed {
        logic dataOut;
        logic dataOeN;
        logic clockOut;
        logic clockOeN;
    } pin_out_t;
endpackage

// *** core/universal_serial_shift_core.sv ***
// universal_serial_shift_core: shift register, clock counter, flags and AXI4-Lite registers
// assumes timer0Match and globalIntEnable come from clk_sys logic; pins are asynchronous
`timescale 1ns/1ns
module universal_serial_shift_core (
    input wire logic clk_sys,
    input wire logic reset,
    input wire usi_pkg::axi_in_t axiIn,
    output usi_pkg::axi_out_t axiOut,
    input wire logic timer0Match,
    input wire logic globalIntEnable,
    input wire usi_pkg::pin_in_t pinIn,
    output usi_pkg::pin_out_t pinOut,
    output logic startIrq,
    output logic overflowIrq,
    output logic wakeFromAnySleep,
    output logic wakeFromIdle
);
    typedef struct packed {
        logic [7:0] serialShiftData;
        logic [7:0] receiveBuffer;
        logic startCondFlag;
        logic overflowFlag;
        logic stopCondFlag;
        logic [3:0] clockCounterValue;
        logic startIrqEnable;
        logic overflowIrqEnable;
        logic [1:0] wireModeSelect;
        logic [1:0] clockSourceSelect;
        logic softwareClockStrobe;
        logic startHold;
        logic outLatch;
        logic [1:0] sclSync;
        logic [1:0] sdaSync;
        logic sclPrev;
        logic sdaPrev;
        logic awHeld;
        logic [usi_pkg::ADDR_W-1:0] awAddr;
        logic wHeld;
        logic [7:0] wData;
        logic wLane;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
    } core_state_t;

    core_state_t s;
    core_state_t next_s;
    logic sclRise;
    logic sclFall;
    logic sclEdge;
    logic startDet;
    logic stopDet;
    logic wrFire;
    logic wrData;
    logic wrStatus;
    logic wrControl;
    logic swStrobe;
    logic tcStrobe;
    logic [1:0] csNow;
    logic clkModeNow;
    logic dataTick;
    logic cntTick;
    logic ovfEvent;
    logic [7:0] shiftNext;
    logic latchOpen;
    logic collision;
    logic twoWire;
    logic sclHold;
    logic rdTake;
    logic [7:0] statusRead;
    logic [7:0] controlRead;
    logic mappedWr;

    ////////////////////////////////////////////////////////////////////////////////
    // next-state logic

    always_comb begin
        next_s = s;
        // pins pass two flops; only the second stage feeds edge and condition logic
        next_s.sclSync = {s.sclSync[0], pinIn.serialClockPin};
        next_s.sdaSync = {s.sdaSync[0], pinIn.serialInPin};
        next_s.sclPrev = s.sclSync[1];
        next_s.sdaPrev = s.sdaSync[1];
        sclRise = s.sclSync[1] & ~s.sclPrev;
        sclFall = ~s.sclSync[1] & s.sclPrev;
        sclEdge = sclRise | sclFall;
        // sampled detector: link clock is slow against clk_sys, so polling suffices
        startDet = s.sclSync[1] & s.sclPrev & s.sdaPrev & ~s.sdaSync[1];
        stopDet = s.sclSync[1] & s.sclPrev & ~s.sdaPrev & s.sdaSync[1];

        // write channels taken independently, response once both are held
        if (axiIn.awvalid && !s.awHeld) begin
            next_s.awHeld = 1'b1;
            next_s.awAddr = axiIn.awaddr;
        end
        if (axiIn.wvalid && !s.wHeld) begin
            next_s.wHeld = 1'b1;
            next_s.wData = axiIn.wdata[7:0];
            next_s.wLane = axiIn.wstrb[0];
        end
        mappedWr = (s.awAddr == usi_pkg::ADDR_DATA) || (s.awAddr == usi_pkg::ADDR_BUFFER)
            || (s.awAddr == usi_pkg::ADDR_STATUS) || (s.awAddr == usi_pkg::ADDR_CONTROL);
        wrFire = s.awHeld & s.wHeld & ~s.bvalid;
        if (wrFire) begin
            next_s.awHeld = 1'b0;
            next_s.wHeld = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = mappedWr ? usi_pkg::RESP_OKAY : usi_pkg::RESP_SLVERR;
        end
        if (s.bvalid && axiIn.bready) begin
            next_s.bvalid = 1'b0;
        end
        // buffer writes are ignored but answered okay: it is read-only
        wrData = wrFire & s.wLane & (s.awAddr == usi_pkg::ADDR_DATA);
        wrStatus = wrFire & s.wLane & (s.awAddr == usi_pkg::ADDR_STATUS);
        wrControl = wrFire & s.wLane & (s.awAddr == usi_pkg::ADDR_CONTROL);
        swStrobe = wrControl & s.wData[usi_pkg::CT_CLK];
        tcStrobe = wrControl & s.wData[usi_pkg::CT_TC];
        // a strobe acts under the clock select written with it
        csNow = wrControl ? s.wData[usi_pkg::CT_CS_HI:usi_pkg::CT_CS_LO] : s.clockSourceSelect;
        clkModeNow = wrControl ? s.wData[usi_pkg::CT_CLK] : s.softwareClockStrobe;

        // clock source selection; pin inputs are used whatever the wire mode
        case (csNow)
            usi_pkg::CS_SOFT: begin
                dataTick = swStrobe;
                cntTick = swStrobe;
            end
            usi_pkg::CS_TIMER: begin
                dataTick = timer0Match;
                cntTick = timer0Match;
            end
            default: begin
                dataTick = csNow[0] ? sclFall : sclRise;
                cntTick = clkModeNow ? tcStrobe : sclEdge;
            end
        endcase

        // cpu write beats a same-cycle shift
        if (wrData) begin
            shiftNext = s.wData;
        end else if (dataTick) begin
            shiftNext = {s.serialShiftData[6:0], s.sdaSync[1]};
        end else begin
            shiftNext = s.serialShiftData;
        end
        next_s.serialShiftData = shiftNext;

        // counter write also beats a same-cycle count
        ovfEvent = cntTick & ~wrStatus & (s.clockCounterValue == usi_pkg::CNT_MAX);
        if (wrStatus) begin
            next_s.clockCounterValue = s.wData[3:0];
        end else if (cntTick) begin
            next_s.clockCounterValue = 4'(s.clockCounterValue + usi_pkg::CNT_ONE);
        end
        if (ovfEvent) begin
            next_s.receiveBuffer = shiftNext;
        end

        // flags: write one clears, a same-cycle event wins
        if (wrStatus && s.wData[usi_pkg::ST_START]) begin
            next_s.startCondFlag = 1'b0;
        end
        if (twoWire ? startDet : (s.clockSourceSelect[1] & ~s.softwareClockStrobe & sclEdge)) begin
            next_s.startCondFlag = 1'b1;
        end
        if (wrStatus && s.wData[usi_pkg::ST_OVF]) begin
            next_s.overflowFlag = 1'b0;
        end
        if (ovfEvent) begin
            next_s.overflowFlag = 1'b1;
        end
        if (wrStatus && s.wData[usi_pkg::ST_STOP]) begin
            next_s.stopCondFlag = 1'b0;
        end
        if (twoWire && stopDet) begin
            next_s.stopCondFlag = 1'b1;
        end

        // start hold grabs scl at the master's falling edge after a start
        if (!next_s.startCondFlag) begin
            next_s.startHold = 1'b0;
        end else if (twoWire && sclFall) begin
            next_s.startHold = 1'b1;
        end

        // output latch follows bit 7 only while open
        latchOpen = ~s.clockSourceSelect[1] | (s.sclSync[1] == s.clockSourceSelect[0]);
        if (latchOpen) begin
            next_s.outLatch = shiftNext[7];
        end

        if (wrControl) begin
            next_s.startIrqEnable = s.wData[usi_pkg::CT_SIE];
            next_s.overflowIrqEnable = s.wData[usi_pkg::CT_OIE];
            next_s.wireModeSelect = s.wData[usi_pkg::CT_WM_HI:usi_pkg::CT_WM_LO];
            next_s.clockSourceSelect = s.wData[usi_pkg::CT_CS_HI:usi_pkg::CT_CS_LO];
            next_s.softwareClockStrobe = s.wData[usi_pkg::CT_CLK];
        end

        // read channel: one read at a time, answered the cycle after it is taken
        rdTake = axiIn.arvalid & ~s.rvalid;
        if (rdTake) begin
            next_s.rvalid = 1'b1;
            next_s.rresp = usi_pkg::RESP_OKAY;
            case (axiIn.araddr)
                usi_pkg::ADDR_DATA: next_s.rdata = s.serialShiftData;
                usi_pkg::ADDR_BUFFER: next_s.rdata = s.receiveBuffer;
                usi_pkg::ADDR_STATUS: next_s.rdata = statusRead;
                usi_pkg::ADDR_CONTROL: next_s.rdata = controlRead;
                default: begin
                    next_s.rdata = usi_pkg::BYTE_ZERO;
                    next_s.rresp = usi_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s.rvalid && axiIn.rready) begin
            next_s.rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register views and outputs

    assign twoWire = s.wireModeSelect[1];
    // only meaningful in two-wire mode, where the data pin is shared
    assign collision = s.serialShiftData[7] ^ s.sdaSync[1];
    assign statusRead = {s.startCondFlag, s.overflowFlag, s.stopCondFlag, collision,
        s.clockCounterValue};
    // strobe bits are write-only and read as zero
    assign controlRead = {s.startIrqEnable, s.overflowIrqEnable, s.wireModeSelect,
        s.clockSourceSelect, 2'h0};

    assign axiOut.awready = ~s.awHeld;
    assign axiOut.wready = ~s.wHeld;
    assign axiOut.bvalid = s.bvalid;
    assign axiOut.bresp = s.bresp;
    assign axiOut.arready = ~s.rvalid;
    assign axiOut.rvalid = s.rvalid;
    assign axiOut.rdata = {24'h000000, s.rdata};
    assign axiOut.rresp = s.rresp;

    // either hold keeps scl low so a slow cpu can stall the master
    assign sclHold = s.startHold
        | ((s.wireModeSelect == usi_pkg::WM_TWO_HOLD) & s.overflowFlag);
    // three-wire drives the latch; two-wire only ever pulls low
    assign pinOut.dataOut = (s.wireModeSelect == usi_pkg::WM_THREE) & s.outLatch;
    assign pinOut.dataOeN = ~(pinIn.dirData & (((s.wireModeSelect == usi_pkg::WM_THREE))
        | (twoWire & (~s.outLatch | ~pinIn.portData))));
    assign pinOut.clockOut = 1'b0;
    assign pinOut.clockOeN = ~(twoWire & pinIn.dirClock
        & (~pinIn.portClock | sclHold));

    // stop flag has no interrupt path
    assign startIrq = s.startCondFlag & s.startIrqEnable & globalIntEnable;
    assign overflowIrq = s.overflowFlag & s.overflowIrqEnable & globalIntEnable;
    assign wakeFromAnySleep = s.startCondFlag & s.startIrqEnable;
    assign wakeFromIdle = s.overflowFlag & s.overflowIrqEnable;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    a_write_beats_shift: assert property (wrData |=> s.serialShiftData == $past(s.wData))
        else $error("cpu data write lost to shift");
    a_shift_left_in: assert property (dataTick && !wrData |=>
        s.serialShiftData == {$past(s.serialShiftData[6:0]), $past(s.sdaSync[1])})
        else $error("shift did not move left");
    a_ext_both_edges: assert property (s.clockSourceSelect[1] && !s.softwareClockStrobe
        && !wrStatus && !wrControl && sclEdge |=>
        s.clockCounterValue == 4'($past(s.clockCounterValue) + 4'h1))
        else $error("external edge not counted");
    a_timer_counts: assert property (s.clockSourceSelect == usi_pkg::CS_TIMER
        && timer0Match && !wrStatus && !wrControl |=>
        s.clockCounterValue == 4'($past(s.clockCounterValue) + 4'h1))
        else $error("timer match not counted");
    a_overflow_wrap: assert property (ovfEvent |=> s.overflowFlag
        && s.clockCounterValue == 4'h0 && s.receiveBuffer == s.serialShiftData)
        else $error("overflow did not set flag, wrap or buffer");
    a_soft_overflow: assert property (swStrobe && csNow == usi_pkg::CS_SOFT && !wrStatus
        && s.clockCounterValue == 4'hF |=> s.overflowFlag)
        else $error("software strobe missed overflow");
    a_flag_sticky: assert property (s.overflowFlag
        && !(wrStatus && s.wData[usi_pkg::ST_OVF]) |=> s.overflowFlag)
        else $error("overflow flag dropped without clear");
    a_status_read: assert property (rdTake && axiIn.araddr == usi_pkg::ADDR_STATUS |=>
        s.rvalid && s.rdata[usi_pkg::ST_COLL] == $past(collision)
        && s.rdata[3:0] == $past(s.clockCounterValue))
        else $error("status read wrong");
    a_latch_internal: assert property (!s.clockSourceSelect[1] |=>
        s.outLatch == s.serialShiftData[7])
        else $error("latch not transparent");
    a_overflow_hold: assert property (s.wireModeSelect == usi_pkg::WM_TWO_HOLD
        && s.overflowFlag && pinIn.dirClock |-> !pinOut.clockOeN)
        else $error("scl not held on overflow");
    a_start_irq: assert property (s.startCondFlag && s.startIrqEnable && globalIntEnable
        |-> startIrq && wakeFromAnySleep)
        else $error("pending start interrupt not raised");
    a_stop_sets: assert property (twoWire && stopDet |=> s.stopCondFlag)
        else $error("stop condition not flagged");

    c_overflow: cover property (ovfEvent);
    c_start_cond: cover property (twoWire && startDet);
    c_stop_cond: cover property (twoWire && stopDet);
    c_clock_hold: cover property (twoWire && pinIn.dirClock && sclHold);
    c_write_resp: cover property (wrFire ##[1:4] (s.bvalid && axiIn.bready));
endmodule

// *** tb/serial_partner.sv ***
// serial_partner: far-side serial device that clocks bit frames into the core
// assumes the core's pin outputs; clock idles low, data line left at the inverse of its last level between frames
`timescale 1ns/1ns
module serial_partner (
    input wire logic go,
    input wire logic [3:0] nBits,
    input wire logic [7:0] txByte,
    input wire logic twoWire,
    input wire usi_pkg::pin_out_t pinOut,
    output logic sckWire,
    output logic sdaWire,
    output logic [7:0] rxByte,
    output logic busy
);
    logic sckDrv = 1'h0;
    logic sdiDrv = 1'h1;
    // open-drain pull-downs from the core win over the partner's level
    assign sckWire = sckDrv & pinOut.clockOeN;
    assign sdaWire = twoWire ? (sdiDrv & pinOut.dataOeN) : sdiDrv;
    initial begin
        busy = 1'h0;
        rxByte = 8'h00;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // odd start offset keeps link edges off the system clock edges
    always @(posedge go) begin
        busy = 1'h1;
        #13;
        // no bits asked: start then stop, data moving while the clock stands high
        if (nBits == 4'h0) begin
            sckDrv = 1'h1;
            #200 sdiDrv = 1'h0;
            #200 sckDrv = 1'h0;
            #200 sckDrv = 1'h1;
            #200 sdiDrv = 1'h1;
            #200 sckDrv = 1'h0;
        end
        for (int i = 0; i < 8; i++) begin
            if (i < nBits) begin
                sdiDrv = txByte[7 - i];
                #200 rxByte = {rxByte[6:0], pinOut.dataOut};
                sckDrv = 1'h1;
                #200 sckDrv = 1'h0;
            end
        end
        // line ends on the inverse of its last driven level, never a stale level
        #300 sdiDrv = ~sdiDrv;
        busy = 1'h0;
    end
endmodule

// *** tb/testbench.sv ***
// testbench: drives the serial shift core over AXI4-Lite and through a serial partner
// assumes usi_pkg byte addresses and one-word registers with data in the low byte
`timescale 1ns/1ns
module testbench;
    logic clk_sys = 1'h0;
    logic reset = 1'h1;
    usi_pkg::axi_in_t ai = '0;
    usi_pkg::axi_out_t ao;
    usi_pkg::pin_in_t pinIn;
    usi_pkg::pin_out_t pinOut;
    logic timer0Match = 1'h0;
    logic globalIntEnable = 1'h0;
    logic dirData = 1'h0;
    logic dirClock = 1'h0;
    logic twoWire = 1'h0;
    logic go = 1'h0;
    logic [3:0] nBits = 4'h0;
    logic [7:0] txByte = 8'h00;
    logic [7:0] rxByte;
    logic sckWire, sdaWire, busy, startIrq, overflowIrq, wakeAny, wakeIdle;
    int nFail = 0;
    int samplesChecked = 0;

    always #25 clk_sys = ~clk_sys;
    assign pinIn = {sckWire, sdaWire, 1'h1, 1'h1, dirData, dirClock};

    universal_serial_shift_core dut (.clk_sys(clk_sys), .reset(reset), .axiIn(ai), .axiOut(ao),
        .timer0Match(timer0Match), .globalIntEnable(globalIntEnable), .pinIn(pinIn),
        .pinOut(pinOut), .startIrq(startIrq), .overflowIrq(overflowIrq),
        .wakeFromAnySleep(wakeAny), .wakeFromIdle(wakeIdle));
    serial_partner partner (.go(go), .nBits(nBits), .txByte(txByte), .twoWire(twoWire),
        .pinOut(pinOut), .sckWire(sckWire), .sdaWire(sdaWire), .rxByte(rxByte), .busy(busy));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samplesChecked++;
        if (got !== exp) begin
            nFail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] addr, input logic [7:0] data, input logic tm,
            input logic [1:0] expResp);
        int n;
        logic aDone;
        logic wDone;
        n = 0;
        aDone = 1'h0;
        wDone = 1'h0;
        @(posedge clk_sys);
        ai.awvalid <= 1'h1;
        ai.awaddr <= addr;
        ai.wvalid <= 1'h1;
        ai.wdata <= {24'h000000, data};
        ai.wstrb <= 4'hF;
        ai.bready <= 1'h1;
        while (!(aDone && wDone)) begin
            @(posedge clk_sys);
            n++;
            if (!aDone && ao.awready) begin
                aDone = 1'h1;
                ai.awvalid <= 1'h0;
            end
            if (!wDone && ao.wready) begin
                wDone = 1'h1;
                ai.wvalid <= 1'h0;
            end
        end
        // timer pulse lands in the same cycle as the register write
        timer0Match <= tm;
        @(posedge clk_sys);
        timer0Match <= 1'h0;
        while (!ao.bvalid) begin
            @(posedge clk_sys);
            n++;
        end
        ai.bready <= 1'h0;
        // both channels taken at the first edge, response one edge after
        check("write wait", 32'h2, n);
        check("write response", {30'h0, expResp}, {30'h0, ao.bresp});
    endtask

    task automatic rd(input logic [7:0] addr, output logic [31:0] data, output logic [1:0] resp);
        int n;
        n = 0;
        @(posedge clk_sys);
        ai.arvalid <= 1'h1;
        ai.araddr <= addr;
        ai.rready <= 1'h1;
        @(posedge clk_sys);
        while (!ao.arready) begin
            @(posedge clk_sys);
            n++;
        end
        ai.arvalid <= 1'h0;
        @(posedge clk_sys);
        while (!ao.rvalid) begin
            @(posedge clk_sys);
            n++;
        end
        data = ao.rdata;
        resp = ao.rresp;
        ai.rready <= 1'h0;
        check("read wait", 32'h0, n);
    endtask

    task automatic expect_reg(input string what, input logic [7:0] addr, input logic [7:0] mask,
            input logic [7:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        rd(addr, d, r);
        check(what, {22'h0, usi_pkg::RESP_OKAY, exp}, {d[31:8] | {22'h0, r}, d[7:0] & mask});
    endtask

    task automatic frame(input logic [3:0] bits, input logic [7:0] tx);
        int n;
        n = 0;
        @(posedge clk_sys);
        nBits <= bits;
        txByte <= tx;
        go <= 1'h1;
        repeat (2) @(posedge clk_sys);
        go <= 1'h0;
        while (busy && n < 2000) begin
            @(posedge clk_sys);
            n++;
        end
        check("frame wait", 32'h0, {31'h0, n >= 2000});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        logic [31:0] d;
        logic [1:0] r;
        expect_reg("control reset", usi_pkg::ADDR_CONTROL, 8'hFF, 8'h00);
        expect_reg("status reset", usi_pkg::ADDR_STATUS, 8'hEF, 8'h00);
        wr(usi_pkg::ADDR_BUFFER, 8'h5A, 1'h0, usi_pkg::RESP_OKAY);
        expect_reg("buffer read only", usi_pkg::ADDR_BUFFER, 8'hFF, 8'h00);
        wr(8'h10, 8'h5A, 1'h0, usi_pkg::RESP_SLVERR);
        rd(8'h10, d, r);
        check("unmapped read", {30'h0, usi_pkg::RESP_SLVERR}, {30'h0, r});
    endtask

    task automatic t_collide;
        twoWire <= 1'h1;
        wr(usi_pkg::ADDR_CONTROL, 8'h20, 1'h0, usi_pkg::RESP_OKAY);
        wr(usi_pkg::ADDR_DATA, 8'h00, 1'h0, usi_pkg::RESP_OKAY);
        repeat (4) @(posedge clk_sys);
        expect_reg("collision set", usi_pkg::ADDR_STATUS, 8'h10, 8'h10);
        wr(usi_pkg::ADDR_DATA, 8'h80, 1'h0, usi_pkg::RESP_OKAY);
        repeat (4) @(posedge clk_sys);
        expect_reg("collision clear", usi_pkg::ADDR_STATUS, 8'h10, 8'h00);
        twoWire <= 1'h0;
    endtask

    task automatic t_soft;
        wr(usi_pkg::ADDR_DATA, 8'h81, 1'h0, usi_pkg::RESP_OKAY);
        wr(usi_pkg::ADDR_STATUS, 8'hEF, 1'h0, usi_pkg::RESP_OKAY);
        wr(usi_pkg::ADDR_CONTROL, 8'h42, 1'h0, usi_pkg::RESP_OKAY);
        expect_reg("soft shift", usi_pkg::ADDR_DATA, 8'hFF, 8'h03);
        expect_reg("soft overflow", usi_pkg::ADDR_STATUS, 8'hCF, 8'h40);
        expect_reg("soft buffer", usi_pkg::ADDR_BUFFER, 8'hFF, 8'h03);
        expect_reg("strobe reads zero", usi_pkg::ADDR_CONTROL, 8'hFF, 8'h40);
        check("idle wake", 32'h1, {31'h0, wakeIdle});
        check("irq gated", 32'h0, {31'h0, overflowIrq});
        globalIntEnable <= 1'h1;
        @(posedge clk_sys);
        check("irq pending", 32'h1, {31'h0, overflowIrq});
        wr(usi_pkg::ADDR_STATUS, 8'h40, 1'h0, usi_pkg::RESP_OKAY);
        check("irq cleared", 32'h0, {31'h0, overflowIrq});
        globalIntEnable <= 1'h0;
    endtask

    task automatic t_timer;
        wr(usi_pkg::ADDR_CONTROL, 8'h04, 1'h0, usi_pkg::RESP_OKAY);
        wr(usi_pkg::ADDR_STATUS, 8'hEE, 1'h0, usi_pkg::RESP_OKAY);
        wr(usi_pkg::ADDR_DATA, 8'h55, 1'h1, usi_pkg::RESP_OKAY);
        expect_reg("write beats shift", usi_pkg::ADDR_DATA, 8'hFF, 8'h55);
        expect_reg("timer count", usi_pkg::ADDR_STATUS, 8'h4F, 8'h0F);
        @(posedge clk_sys);
        timer0Match <= 1'h1;
        @(posedge clk_sys);
        timer0Match <= 1'h0;
        expect_reg("timer shift", usi_pkg::ADDR_DATA, 8'hFF, 8'hAB);
        expect_reg("timer wrap", usi_pkg::ADDR_STATUS, 8'h4F, 8'h40);
        expect_reg("timer buffer", usi_pkg::ADDR_BUFFER, 8'hFF, 8'hAB);
    endtask

    task automatic t_toggle;
        wr(usi_pkg::ADDR_STATUS, 8'hE0, 1'h0, usi_pkg::RESP_OKAY);
        wr(usi_pkg::ADDR_CONTROL, 8'h0A, 1'h0, usi_pkg::RESP_OKAY);
        wr(usi_pkg::ADDR_CONTROL, 8'h0B, 1'h0, usi_pkg::RESP_OKAY);
        wr(usi_pkg::ADDR_CONTROL, 8'h0B, 1'h0, usi_pkg::RESP_OKAY);
        expect_reg("toggle count", usi_pkg::ADDR_STATUS, 8'h0F, 8'h02);
    endtask

    task automatic t_edge;
        wr(usi_pkg::ADDR_CONTROL, 8'h88, 1'h0, usi_pkg::RESP_OKAY);
        wr(usi_pkg::ADDR_STATUS, 8'hEF, 1'h0, usi_pkg::RESP_OKAY);
        frame(4'h1, 8'h00);
        expect_reg("edge interrupt", usi_pkg::ADDR_STATUS, 8'hCF, 8'hC1);
        globalIntEnable <= 1'h1;
        @(posedge clk_sys);
        check("start irq", 32'h1, {31'h0, startIrq});
        check("start wake", 32'h1, {31'h0, wakeAny});
        wr(usi_pkg::ADDR_STATUS, 8'hC0, 1'h0, usi_pkg::RESP_OKAY);
        check("start cleared", 32'h0, {31'h0, startIrq});
        globalIntEnable <= 1'h0;
    endtask

    task automatic t_spi;
        dirData <= 1'h1;
        wr(usi_pkg::ADDR_CONTROL, 8'h18, 1'h0, usi_pkg::RESP_OKAY);
        wr(usi_pkg::ADDR_STATUS, 8'hE0, 1'h0, usi_pkg::RESP_OKAY);
        wr(usi_pkg::ADDR_DATA, 8'hA5, 1'h0, usi_pkg::RESP_OKAY);
        @(posedge clk_sys);
        check("data drive on", 32'h0, {31'h0, pinOut.dataOeN});
        check("latch shows msb", 32'h1, {31'h0, pinOut.dataOut});
        frame(4'h8, 8'h3C);
        check("partner byte", 32'hA5, {24'h0, rxByte});
        expect_reg("shifted in", usi_pkg::ADDR_DATA, 8'hFF, 8'h3C);
        expect_reg("byte done", usi_pkg::ADDR_STATUS, 8'h4F, 8'h40);
        expect_reg("spi buffer", usi_pkg::ADDR_BUFFER, 8'hFF, 8'h3C);
        dirData <= 1'h0;
    endtask

    task automatic t_two_wire;
        twoWire <= 1'h1;
        wr(usi_pkg::ADDR_CONTROL, 8'h20, 1'h0, usi_pkg::RESP_OKAY);
        wr(usi_pkg::ADDR_STATUS, 8'hE0, 1'h0, usi_pkg::RESP_OKAY);
        frame(4'h0, 8'h00);
        expect_reg("start and stop", usi_pkg::ADDR_STATUS, 8'hE0, 8'hA0);
        dirClock <= 1'h1;
        @(posedge clk_sys);
        check("start hold", 32'h0, {31'h0, pinOut.clockOeN});
        check("clock pulls low", 32'h0, {31'h0, pinOut.clockOut});
        wr(usi_pkg::ADDR_STATUS, 8'h8F, 1'h0, usi_pkg::RESP_OKAY);
        check("start release", 32'h1, {31'h0, pinOut.clockOeN});
        wr(usi_pkg::ADDR_CONTROL, 8'h32, 1'h0, usi_pkg::RESP_OKAY);
        check("overflow hold", 32'h0, {31'h0, pinOut.clockOeN});
        wr(usi_pkg::ADDR_STATUS, 8'h40, 1'h0, usi_pkg::RESP_OKAY);
        check("overflow release", 32'h1, {31'h0, pinOut.clockOeN});
        dirClock <= 1'h0;
        twoWire <= 1'h0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("checks %0d failures %0d", samplesChecked, nFail);
        if (nFail == 0 && samplesChecked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clk_sys);
        reset <= 1'h0;
        t_reset;
        t_collide;
        t_soft;
        t_timer;
        t_toggle;
        t_edge;
        t_spi;
        t_two_wire;
        close_out;
    end

    // generous bound: the whole sequence needs well under a tenth of this
    initial begin
        repeat (20000) @(posedge clk_sys);
        nFail++;
        $display("watchdog expired");
        close_out;
    end
endmodule
